// [spi_parity_pkg.sv]
/*
  Constants shared by the serial parity port of the dual-axis sensor.
  Assumes a 100 MHz system clock and a host-driven serial clock.
*/
package spi_parity_pkg;
  // ==================================================================
  // Frame layout
  localparam int WORD_BITS = 16;
  localparam logic [4:0] BIT_COUNT_FULL = 5'h10;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // Bit of the answer word that carries the transient exception flag
  localparam int EXC_BIT_POS = 14;
  // Bits that carry the selected axis value in the answer word
  localparam int AXIS_FIELD_LSB = 0;
  localparam int AXIS_FIELD_W = 11;

  // ==================================================================
  // Hardware reset timing, self-test offset and axis midpoint
  localparam int SYS_CLK_MHZ = 100;
  localparam int HW_RESET_HOLD_US = 512;
  localparam int HW_RESET_CYCLES = HW_RESET_HOLD_US * SYS_CLK_MHZ;
  localparam logic [10:0] SELF_TEST_OFFSET = 11'h040;
  localparam logic [10:0] AXIS_MID = 11'h400;
endpackage

// [sensor_spi_parity_port.sv]
/*
  Serial slave port of a dual-axis acceleration sensor: 16-bit odd-parity
  words both ways except all-ones answers under oscillator fault, oscillator fault signalling, pin-driven hardware reset.
  Assumes the host keeps the serial clock low between frames (mode 0) and
  that sensor data, fault and self-test inputs are steady on clk_sys_i.
*/
`timescale 1ns/1ns
// Overview of operation
// - Sample serial input on rising serial clock
// - Drive serial output only while select low
// - Select low, clock high 512 us resets
// - Every shifted-out word has odd parity except under oscillator fault
// - Oscillator fault forces output high whenever select is low
// - Bad parity flagged in next transfer
// - Self-test shifts axes by polarity bit
module sensor_spi_parity_port
  import spi_parity_pkg::*;
#(
  parameter int HW_RESET_COUNT = HW_RESET_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  input wire logic osc_fault_i,
  input wire logic self_test_i,
  input wire logic self_test_polarity_i,
  input wire logic [10:0] axis_x_i,
  input wire logic [10:0] axis_y_i,
  input wire logic axis_sel_i,
  output logic [15:0] rx_word_o,
  output logic rx_valid_o,
  output logic hw_reset_o
);

  // ==================================================================
  // System domain: answer word build-up
  logic [10:0] axis_raw;
  logic [10:0] axis_adj;
  logic [15:0] tx_body;
  logic [15:0] tx_word_sys;
  logic exc_pending;
  assign axis_raw = axis_sel_i ? axis_y_i : axis_x_i;
  assign axis_adj = !self_test_i ? axis_raw :
                    self_test_polarity_i ? 11'(axis_raw - SELF_TEST_OFFSET) :
                    11'(axis_raw + SELF_TEST_OFFSET);
  // Bit 15 is the parity bit, chosen so the whole word has odd weight
  assign tx_body = {1'b0, exc_pending, 3'h0, axis_adj};
  assign tx_word_sys = {~^tx_body[14:0], tx_body[14:0]};

  // ==================================================================
  // Pin synchronisers into the system domain
  logic [1:0] cs_sync;
  logic [1:0] sclk_sync;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_sync <= 2'h3;
      sclk_sync <= 2'h0;
    end else begin
      cs_sync <= {cs_sync[0], cs_n_i};
      sclk_sync <= {sclk_sync[0], sclk_i};
    end
  end
  wire cs_n_s = cs_sync[1];
  wire sclk_s = sclk_sync[1];

  // Hold counter for the pin-driven reset; the counter width covers
  // the full default figure, shorter parameters just stop earlier.
  logic [31:0] hold_cnt;
  logic [31:0] next_hold_cnt;
  wire hold_state = !cs_n_s && sclk_s;
  wire hold_done = (hold_cnt >= 32'(HW_RESET_COUNT - 1));
  assign next_hold_cnt = !hold_state ? 32'h0 :
                         hold_done ? hold_cnt : 32'(hold_cnt + 32'h1);
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_cnt <= 32'h0;
      hw_reset_o <= 1'b0;
    end else begin
      hold_cnt <= next_hold_cnt;
      hw_reset_o <= hold_state && hold_done;
    end
  end

  // ==================================================================
  // Link domain: shift on the serial clock, frame held by chip select.
  // Chip select high acts as the frame reset so no edge outside a frame
  // is needed to restart the bit counter.
  logic [15:0] shift_in;
  logic [4:0] bit_cnt;
  logic [15:0] shift_out;
  logic first_edge_done;
  wire frame_rst_n = resetn_i && !cs_n_i;
  always_ff @(posedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      shift_in <= WORD_RESET;
      bit_cnt <= 5'h0;
    end else begin
      shift_in <= {shift_in[14:0], din_i};
      if (bit_cnt != BIT_COUNT_FULL) begin
        bit_cnt <= 5'(bit_cnt + 5'h1);
      end
    end
  end

  // Answer word is loaded while deselected from the system domain.
  // It only changes between frames, so it is quasi-static when sampled.
  logic [15:0] tx_hold;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_hold <= WORD_RESET;
    end else if (cs_n_s) begin
      tx_hold <= tx_word_sys;
    end
  end

  // MSB goes out as soon as select falls; bit 14 after the first rising edge, later bits on falling edges
  always_ff @(negedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      shift_out <= WORD_RESET;
      first_edge_done <= 1'b0;
    end else begin
      first_edge_done <= 1'b1;
      // Bit 15 went out before the first falling edge, so bit 14 follows it
      shift_out <= first_edge_done ? {shift_out[14:0], 1'b0} : {tx_hold[14:0], 1'b0};
    end
  end
  wire tx_bit = first_edge_done ? shift_out[15] : tx_hold[14];
  wire tx_first = !first_edge_done && !(bit_cnt != 5'h0);
  assign dout_oe_o = !cs_n_i;
  assign dout_o = cs_n_i ? 1'b0 :
                  osc_fault_i ? 1'b1 :
                  tx_first ? tx_hold[15] : tx_bit;

  // ==================================================================
  // Frame end: the rising select edge takes the word and bit count before
  // the frame reset clears them. The copies stay frozen while deselected,
  // so the system side reads them only after the synchronised edge.
  logic [15:0] rx_stage;
  logic [4:0] cnt_stage;
  logic cs_prev;
  wire frame_end = cs_n_s && !cs_prev;
  always_ff @(posedge cs_n_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_stage <= WORD_RESET;
      cnt_stage <= 5'h0;
    end else begin
      rx_stage <= shift_in;
      cnt_stage <= bit_cnt;
    end
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_prev <= 1'b1;
    end else begin
      cs_prev <= cs_n_s;
    end
  end

  // Odd weight over all sixteen bits; a short frame also counts as bad
  wire rx_parity_ok = (^rx_stage) && (cnt_stage == BIT_COUNT_FULL);
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      exc_pending <= 1'b0;
      rx_word_o <= WORD_RESET;
      rx_valid_o <= 1'b0;
    end else begin
      rx_valid_o <= frame_end && rx_parity_ok;
      if (frame_end) begin
        // Reported in the next frame, then held until a frame with good parity ends
        exc_pending <= !rx_parity_ok;
        if (rx_parity_ok) begin
          rx_word_o <= rx_stage;
        end
      end
    end
  end

endmodule

// [sensor_spi_parity_port_asserts.sv]
/* Pin assertions for the sensor serial port; assumes one system clock domain. */
`timescale 1ns/1ns
module sensor_spi_parity_port_asserts (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic osc_fault_i,
  input wire logic [15:0] rx_word_o,
  input wire logic rx_valid_o,
  input wire logic hw_reset_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  a_oe_select: assert property (dout_oe_o == !cs_n_i) else $error("oe");
  a_fault_high: assert property (osc_fault_i && !cs_n_i |-> dout_o) else $error("flt");
  a_cs_idle: assert property (cs_n_i [*6] |-> !hw_reset_o) else $error("rst");
  a_sclk_low: assert property (!sclk_i [*6] |-> !hw_reset_o) else $error("rst");
  a_valid_pulse: assert property (rx_valid_o |=> !rx_valid_o) else $error("vld");
  a_valid_late: assert property (rx_valid_o |-> $past(cs_n_i, 2)) else $error("vld");
  a_word_valid: assert property ($changed(rx_word_o) |-> rx_valid_o) else $error("rx");
  a_word_odd: assert property (rx_valid_o |-> ^rx_word_o) else $error("rx");
  cover property (rx_valid_o);
  cover property (hw_reset_o);
  cover property (osc_fault_i && !cs_n_i);
endmodule
bind sensor_spi_parity_port sensor_spi_parity_port_asserts i_asserts (.clk_sys_i, .resetn_i,
  .sclk_i, .cs_n_i, .dout_o, .dout_oe_o, .osc_fault_i, .rx_word_o, .rx_valid_o, .hw_reset_o);

// [spi_host_model.sv]
/* Host serial controller, mode 0; assumes the caller spaces frames. */
`timescale 1ns/1ns
module spi_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  input wire logic dout_i
);
  // Clock stands low between frames, din rests at its pull-down level
  initial {sclk_o, cs_n_o, din_o} = 3'b010;
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rx);
    {din_o, cs_n_o} = {w[15], 1'b0};
    for (int i = 0; i < n; i++) begin
      #6 rx = {rx[14:0], dout_i};
      sclk_o = 1'b1;
      #6 sclk_o = 1'b0;
      w = w << 1;
      din_o = w[15];
    end
    #6 {din_o, cs_n_o} = 2'b01;
  endtask
  task automatic hold(input int t);
    {sclk_o, cs_n_o} = 2'b10;
    #(t) {sclk_o, cs_n_o} = 2'b01;
  endtask
endmodule

// [tb_sensor_spi_parity_port.sv]
/* Bench for the sensor serial port; assumes a reset hold count of 64. */
`timescale 1ns/1ns
module tb_sensor_spi_parity_port;
  import spi_parity_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, flt = 1'b0, st = 1'b0, pol = 1'b0;
  logic sck, csn, di, so, oe, vld, hr;
  logic [15:0] rxw, ans;
  int fail_count = 0, num_checks = 0;
  initial forever #5 clk = ~clk;
  spi_host_model i_spi_host_model (.sclk_o(sck), .cs_n_o(csn), .din_o(di),
    .dout_i(oe ? so : ~so));
  sensor_spi_parity_port #(.HW_RESET_COUNT(64)) i_sensor_spi_parity_port (.clk_sys_i(clk),
    .resetn_i(rstn), .sclk_i(sck), .cs_n_i(csn), .din_i(di), .dout_o(so), .dout_oe_o(oe),
    .osc_fault_i(flt), .self_test_i(st), .self_test_polarity_i(pol), .axis_x_i(11'h123),
    .axis_y_i(11'h456), .axis_sel_i(pol), .rx_word_o(rxw), .rx_valid_o(vld), .hw_reset_o(hr));
  task automatic chk(input logic [15:0] g, e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %0t: %h not %h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic frame(input logic [15:0] w, input int n, input logic ok);
    logic seen = 1'b0;
    i_spi_host_model.xfer(w, n, ans);
    repeat (8) @(negedge clk) seen |= vld;
    chk(seen, ok);
    if (ok) chk(rxw, w);
    if (seen !== ok) test_done;
  endtask
  task automatic t_parity;
    frame(16'h0003, 16, 1'b0);
    chk(ans[14], 1'b0);
    frame(16'h8000, 16, 1'b1);
    chk({ans[14], ^ans}, 2'b11);
    frame(16'h0001, 15, 1'b0);
    frame(16'h0002, 16, 1'b1);
    chk(ans[14], 1'b1);
    frame(16'h0004, 16, 1'b1);
    chk(ans[14], 1'b0);
    $display("parity end");
  endtask
  task automatic t_self;
    for (int p = 0; p < 2; p++) begin
      @(posedge clk) #1;
      {st, pol} = {1'b1, p[0]};
      frame(16'h4000, 16, 1'b1);
      chk(ans[10:0], p ? 11'h456 - SELF_TEST_OFFSET : 11'h123 + SELF_TEST_OFFSET);
    end
    $display("self-test end");
  endtask
  task automatic t_fault;
    @(posedge clk) #1;
    {st, flt} = 2'b01;
    frame(16'h1000, 16, 1'b1);
    chk(ans, 16'hFFFF);
    $display("fault end");
  endtask
  task automatic t_hold;
    fork
      i_spi_host_model.hold(400);
      #390 chk(hr, 1'b0);
    join
    #60;
    fork
      i_spi_host_model.hold(800);
      #790 chk(hr, 1'b1);
    join
    #60 chk(hr, 1'b0);
    $display("hold end");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk);
    t_parity;
    t_self;
    t_fault;
    t_hold;
    test_done;
  end
endmodule
